// ===== mcuic_pkg.sv
// Constants shared by the interrupt controller and its arbiter.
// Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
package mcuic_pkg;

  // Source table: fifteen peripheral sources plus the shared ECC entry
  localparam int unsigned NUM_SRC = 16;
  localparam int unsigned SRC_IDX_W = 4;
  localparam int unsigned SEL_W = 5;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IE = 8'ha8;
  localparam logic [7:0] ADDR_IP = 8'hb8;
  localparam logic [7:0] ADDR_EXT_SOURCE_ENABLE = 8'he8;

  // Values after reset
  localparam logic [7:0] RST_IE = 8'h00;
  localparam logic [7:0] RST_IP = 8'h00;
  localparam logic [7:0] RST_EXT_SOURCE_ENABLE = 8'h00;
  localparam logic [15:0] RST_CTRL = 16'h0000;

  // Field positions
  localparam int unsigned IE_GLOBAL_BIT = 7;
  localparam int unsigned CTRL_RELOC_BIT = 0;
  localparam int unsigned CTRL_MSIZE_LSB = 1;
  localparam int unsigned CTRL_DBGPORT_BIT = 3;
  localparam int unsigned CTRL_DBGID_LSB = 8;
  localparam int unsigned FLAG_BKP_BIT = 16;
  localparam int unsigned FLAG_DBG_BIT = 17;

  // Vector layout
  localparam logic [11:0] VEC_FIRST = 12'h003;
  localparam int unsigned VEC_STEP_SHIFT = 3;
  localparam logic [11:0] VEC_BKP = 12'h080;
  localparam logic [11:0] VEC_DBG = 12'h0c0;
  localparam logic [1:0] RELOC_LOW_NIBBLE = 2'h3;

  // Source selectors
  localparam logic [SEL_W-1:0] SEL_TIMER0 = 5'h01;
  localparam logic [SEL_W-1:0] SEL_TIMER1 = 5'h03;
  localparam logic [SEL_W-1:0] SEL_BKP = 5'h10;
  localparam logic [SEL_W-1:0] SEL_DBG = 5'h11;

  // Service levels, ordered so that a larger code outranks a smaller one
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_DEBUG = 2'h3;

endpackage

// ===== mcuic_arbiter.sv
// Fixed-order arbiter: lowest table index wins within each level.
// Assumes pending and priority vectors come from flops on the same clock.
`timescale 1ns/10ps
module mcuic_arbiter #(
  parameter int unsigned NUM = 16,
  parameter int unsigned IDX_W = 4
) (
  // Pending sources and their level bits
  input wire logic [NUM-1:0] i_pend,
  input wire logic [NUM-1:0] i_prio,
  // Winners per level
  output logic o_hi_any,
  output logic [IDX_W-1:0] o_hi_idx,
  output logic o_lo_any,
  output logic [IDX_W-1:0] o_lo_idx
);

  // Scan from the top so the lowest index is the last to write
  always_comb
  begin
    o_hi_any = 1'b0;
    o_hi_idx = '0;
    o_lo_any = 1'b0;
    o_lo_idx = '0;
    for (int i = NUM - 1; i >= 0; i--)
    begin
      if (i_pend[i] && i_prio[i])
      begin
        o_hi_any = 1'b1;
        o_hi_idx = IDX_W'(i);
      end
      if (i_pend[i] && !i_prio[i])
      begin
        o_lo_any = 1'b1;
        o_lo_idx = IDX_W'(i);
      end
    end
  end

endmodule

// ===== mcuic_top.sv
// Interrupt controller: flags, enables, two-level arbitration, vectors.
// Assumes a single-slave AHB-Lite bus, a CPU ack/return pulse pair and
// request lines from logic on the same clock.
`timescale 1ns/10ps
module mcuic_top #(
  parameter int unsigned ADDR_W = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [ADDR_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Interrupt sources
  input wire logic [mcuic_pkg::NUM_SRC-1:0] i_src_irq,
  input wire logic i_bkpt_match,
  input wire logic i_dbg_req,
  input wire logic [7:0] i_dbg_req_id,
  // CPU side
  input wire logic i_irq_ack,
  input wire logic i_reti,
  output logic o_irq_req,
  output logic [15:0] o_irq_vector,
  output logic [mcuic_pkg::SEL_W-1:0] o_irq_source,
  output logic [1:0] o_irq_level
);

  localparam int unsigned N = mcuic_pkg::NUM_SRC;

  logic [7:0] ie_r;
  logic [7:0] ip_r;
  logic [7:0] ext_source_enable_r;
  logic [15:0] ctrl_r;
  logic [N-1:0] src_sample_r;
  logic [N-1:0] flags_r;
  logic bkp_flag_r;
  logic dbg_flag_r;
  logic [2:0] in_svc_r;
  logic ph_write_r;
  logic [7:0] ph_addr_r;
  logic [31:0] rdata_nxt;
  logic [N-1:0] src_en;
  logic [N-1:0] src_prio;
  logic [N-1:0] pend;
  logic [N-1:0] hw_clr;
  logic [N-1:0] sw_clr;
  logic hi_any;
  logic lo_any;
  logic [mcuic_pkg::SRC_IDX_W-1:0] hi_idx;
  logic [mcuic_pkg::SRC_IDX_W-1:0] lo_idx;
  logic [1:0] cur_level;
  logic [3:0] vec_nibble;
  logic take_addr;
  logic wr_flags;
  logic req_nxt;
  logic [mcuic_pkg::SEL_W-1:0] sel_nxt;
  logic [1:0] lvl_nxt;
  logic [11:0] vec_off;

  // Address phase accepted when selected and non-idle
  assign take_addr = i_hsel && i_hready && i_htrans[1];

  // Capture address phase for the data phase that follows
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ph_write_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end
    else if (i_hready)
    begin
      ph_write_r <= take_addr && i_hwrite;
      ph_addr_r <= {i_haddr[7:2], 2'b00};
    end
  end

  // Zero-wait slave, always OKAY, same value in and out of reset
  always_ff @(posedge i_clk)
  begin
    o_hreadyout <= 1'b1;
    o_hresp <= 1'b0;
  end

  // Read mux; unmapped and reserved bits read zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case ({i_haddr[7:2], 2'b00})
      mcuic_pkg::ADDR_IE: rdata_nxt = {24'h000000, ie_r};
      mcuic_pkg::ADDR_IP: rdata_nxt = {24'h000000, 1'b0, ip_r[6:0]};
      mcuic_pkg::ADDR_EXT_SOURCE_ENABLE: rdata_nxt = {24'h000000, ext_source_enable_r};
      mcuic_pkg::ADDR_CTRL: rdata_nxt = {16'h0000, ctrl_r};
      mcuic_pkg::ADDR_FLAGS: rdata_nxt = {14'h0000, dbg_flag_r, bkp_flag_r, flags_r};
      mcuic_pkg::ADDR_STATUS: rdata_nxt = {27'h0000000, in_svc_r, cur_level};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data stands through the data phase
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_hrdata <= 32'h0000_0000;
    else if (take_addr && !i_hwrite)
      o_hrdata <= rdata_nxt;
  end

  // basic enable register, global bit on top
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      ie_r <= mcuic_pkg::RST_IE;
    else if (ph_write_r && ph_addr_r == mcuic_pkg::ADDR_IE)
      ie_r <= i_hwdata[7:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      ip_r <= mcuic_pkg::RST_IP;
    else if (ph_write_r && ph_addr_r == mcuic_pkg::ADDR_IP)
      ip_r <= {1'b0, i_hwdata[6:0]};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      ext_source_enable_r <= mcuic_pkg::RST_EXT_SOURCE_ENABLE;
    else if (ph_write_r && ph_addr_r == mcuic_pkg::ADDR_EXT_SOURCE_ENABLE)
      ext_source_enable_r <= i_hwdata[7:0];
  end

  // Relocation, memory size, debug port enable and debug identifier
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      ctrl_r <= mcuic_pkg::RST_CTRL;
    else if (ph_write_r && ph_addr_r == mcuic_pkg::ADDR_CTRL)
      ctrl_r <= {i_hwdata[15:8], 4'h0, i_hwdata[3:0]};
  end

  // register every request line once per edge
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      src_sample_r <= '0;
    else
      src_sample_r <= i_src_irq;
  end

  // per-source enable and level vectors over the table
  // index 0 and 2 are pin groups, 0..6 core, 7..14 peripherals
  // enables from the two enable registers, ECC entry always on
  // a set priority bit selects the high level
  assign src_en = {1'b1, ext_source_enable_r, ie_r[6:0]};
  assign src_prio = {9'h000, ip_r[6:0]};

  // Write-one-to-clear strobe into the flag register
  assign wr_flags = ph_write_r && ph_addr_r == mcuic_pkg::ADDR_FLAGS;

  // only the two timer entries are self-clearing
  // cleared in the cycle the CPU acknowledges their vector
  always_comb
  begin
    hw_clr = '0;
    hw_clr[1] = i_irq_ack && o_irq_req && o_irq_source == mcuic_pkg::SEL_TIMER0;
    hw_clr[3] = i_irq_ack && o_irq_req && o_irq_source == mcuic_pkg::SEL_TIMER1;
  end

  // software clear reaches every other flag, I2C master included
  assign sw_clr = wr_flags ? (i_hwdata[N-1:0] & ~16'h000a) : '0;

  // writes only clear; a new event wins over any clear
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      flags_r <= '0;
    else
      flags_r <= src_sample_r | (flags_r & ~(sw_clr | hw_clr));
  end

  // debug request matching the identifier on an enabled port
  // breakpoint match sets its own flag
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      bkp_flag_r <= 1'b0;
      dbg_flag_r <= 1'b0;
    end
    else
    begin
      bkp_flag_r <= i_bkpt_match
        || (bkp_flag_r && !(wr_flags && i_hwdata[mcuic_pkg::FLAG_BKP_BIT]));
      dbg_flag_r <= (i_dbg_req && ctrl_r[mcuic_pkg::CTRL_DBGPORT_BIT]
        && i_dbg_req_id == ctrl_r[mcuic_pkg::CTRL_DBGID_LSB +: 8])
        || (dbg_flag_r && !(wr_flags && i_hwdata[mcuic_pkg::FLAG_DBG_BIT]));
    end
  end

  // Gate pending flags by enables and the global bit
  assign pend = flags_r & src_en & {N{ie_r[mcuic_pkg::IE_GLOBAL_BIT]}};

  // table order resolved inside the arbiter
  mcuic_arbiter #(
    .NUM(N),
    .IDX_W(mcuic_pkg::SRC_IDX_W)
  ) u_arb (
    .i_pend(pend),
    .i_prio(src_prio),
    .o_hi_any(hi_any),
    .o_hi_idx(hi_idx),
    .o_lo_any(lo_any),
    .o_lo_idx(lo_idx)
  );

  // Level of the routine now running
  assign cur_level = in_svc_r[2] ? mcuic_pkg::LVL_DEBUG
    : in_svc_r[1] ? mcuic_pkg::LVL_HIGH
    : in_svc_r[0] ? mcuic_pkg::LVL_LOW : mcuic_pkg::LVL_NONE;

  // pick the winner; high before low
  // debug, then breakpoint, above all sources
  // those two bypass the global enable
  // grant only above the running level
  always_comb
  begin
    req_nxt = 1'b0;
    sel_nxt = '0;
    lvl_nxt = mcuic_pkg::LVL_NONE;
    if ((dbg_flag_r || bkp_flag_r) && cur_level < mcuic_pkg::LVL_DEBUG)
    begin
      req_nxt = 1'b1;
      sel_nxt = dbg_flag_r ? mcuic_pkg::SEL_DBG : mcuic_pkg::SEL_BKP;
      lvl_nxt = mcuic_pkg::LVL_DEBUG;
    end
    else if (hi_any && cur_level < mcuic_pkg::LVL_HIGH)
    begin
      req_nxt = 1'b1;
      sel_nxt = {1'b0, hi_idx};
      lvl_nxt = mcuic_pkg::LVL_HIGH;
    end
    else if (lo_any && cur_level < mcuic_pkg::LVL_LOW)
    begin
      req_nxt = 1'b1;
      sel_nxt = {1'b0, lo_idx};
      lvl_nxt = mcuic_pkg::LVL_LOW;
    end
    if (i_irq_ack && o_irq_req)
      req_nxt = 1'b0;
  end

  // fixed offset per entry; debug and breakpoint fixed slots
  assign vec_off = (sel_nxt == mcuic_pkg::SEL_DBG) ? mcuic_pkg::VEC_DBG
    : (sel_nxt == mcuic_pkg::SEL_BKP) ? mcuic_pkg::VEC_BKP
    : (mcuic_pkg::VEC_FIRST | {5'h00, sel_nxt[3:0], 3'h0});

  // top nibble follows memory size when relocated
  assign vec_nibble = ctrl_r[mcuic_pkg::CTRL_RELOC_BIT]
    ? {ctrl_r[mcuic_pkg::CTRL_MSIZE_LSB +: 2], mcuic_pkg::RELOC_LOW_NIBBLE} : 4'h0;

  // Registered request towards the CPU
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_irq_req <= 1'b0;
      o_irq_vector <= 16'h0000;
      o_irq_source <= '0;
      o_irq_level <= mcuic_pkg::LVL_NONE;
    end
    else
    begin
      o_irq_req <= req_nxt;
      o_irq_vector <= {vec_nibble, vec_off};
      o_irq_source <= sel_nxt;
      o_irq_level <= lvl_nxt;
    end
  end

  // In-service levels: set on ack, highest cleared on return
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      in_svc_r <= 3'h0;
    else if (i_irq_ack && o_irq_req)
      in_svc_r <= in_svc_r | (3'h1 << (o_irq_level - 2'h1));
    else if (i_reti)
      in_svc_r <= in_svc_r[2] ? {1'b0, in_svc_r[1:0]}
        : in_svc_r[1] ? {2'b00, in_svc_r[0]} : 3'h0;
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_timer_ack;
    i_irq_ack && o_irq_req
      && (o_irq_source == mcuic_pkg::SEL_TIMER0 || o_irq_source == mcuic_pkg::SEL_TIMER1);
  endsequence

  a_timer_hw_clear: assert property (s_timer_ack |=> $past(1'b1) ##0
    (!flags_r[$past(o_irq_source[3:0])] || $past(src_sample_r[o_irq_source[3:0]])))
    else $error("timer flag not cleared on ack");
  a_sw_never_sets: assert property ((flags_r & ~$past(flags_r) & ~$past(src_sample_r))
    == '0) else $error("flag set without source event");
  a_debug_first: assert property ((dbg_flag_r && !in_svc_r[2] && !i_irq_ack)
    |=> o_irq_req && o_irq_source == mcuic_pkg::SEL_DBG)
    else $error("debug request not presented first");
  a_high_over_low: assert property ((hi_any && lo_any && in_svc_r == 3'h0
    && !dbg_flag_r && !bkp_flag_r && !i_irq_ack)
    |=> o_irq_level == mcuic_pkg::LVL_HIGH && o_irq_source == {1'b0, $past(hi_idx)})
    else $error("low level served before high");
  a_vector_normal: assert property ((o_irq_req && !o_irq_source[4]
    && !$past(ctrl_r[mcuic_pkg::CTRL_RELOC_BIT]))
    |-> o_irq_vector == (16'h0003 + {8'h00, o_irq_source[3:0], 3'h0}))
    else $error("normal vector wrong");
  a_vector_reloc: assert property ((o_irq_req && $past(ctrl_r[mcuic_pkg::CTRL_RELOC_BIT]))
    |-> o_irq_vector[15:12] == {$past(ctrl_r[2:1]), 2'b11})
    else $error("relocated vector nibble wrong");
  a_no_preempt_eq: assert property (o_irq_req |-> o_irq_level > $past(cur_level))
    else $error("request not above running level");
  a_global_gate: assert property (o_irq_req && !o_irq_source[4]
    |-> $past(ie_r[mcuic_pkg::IE_GLOBAL_BIT]))
    else $error("source served with global enable off");
  a_sample_set: assert property (i_src_irq[7] |=> ##1 flags_r[7])
    else $error("sampled request did not set flag");
  a_bus_okay: assert property (take_addr |=> o_hreadyout && !o_hresp)
    else $error("bus answer not ready okay");

endmodule

// ===== mcuic_cpu_model.sv
// CPU core model: takes vectors from the interrupt controller and returns.
// Assumes registered requests from the controller on the same clock.
`timescale 1ns/10ps
module mcuic_cpu_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Controller side
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vector,
  input wire logic [4:0] i_irq_source,
  input wire logic [1:0] i_irq_level,
  output logic o_irq_ack,
  output logic o_reti,
  // Bench control and log
  input wire logic [3:0] i_delay,
  input wire logic [3:0] i_svc,
  output int o_takes,
  output logic [15:0] o_vec,
  output logic [4:0] o_src,
  output logic [1:0] o_lvl
);
  logic [3:0] wait_r;
  logic [3:0] svc_r;
  logic [3:0] depth_r;
  logic taken;
  assign taken = o_irq_ack & i_irq_req;
  // Ack after a chosen delay, one pulse per request
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !i_irq_req || o_irq_ack || o_reti)
    begin
      o_irq_ack <= 1'b0;
      wait_r <= 4'h0;
    end
    else
    begin
      o_irq_ack <= (wait_r == i_delay);
      wait_r <= (wait_r == i_delay) ? 4'h0 : wait_r + 4'h1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_takes <= 0;
    end
    else if (taken)
    begin
      o_takes <= o_takes + 1;
      o_vec <= i_irq_vector;
      o_src <= i_irq_source;
      o_lvl <= i_irq_level;
    end
  end
  // Return from each nested routine after i_svc cycles; 0 never returns
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_reti <= 1'b0;
      svc_r <= 4'h0;
      depth_r <= 4'h0;
    end
    else
    begin
      depth_r <= depth_r + {3'h0, taken} - {3'h0, o_reti};
      o_reti <= 1'b0;
      if (depth_r != 4'h0 && i_svc != 4'h0 && !o_reti)
      begin
        o_reti <= (svc_r == i_svc);
        svc_r <= (svc_r == i_svc) ? 4'h0 : svc_r + 4'h1;
      end
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the interrupt controller and a CPU model.
// Assumes the controller answers the bus with no wait states.
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [7:0] ie, ext_source_enable, ip; logic [15:0] ctrl, src; logic [4:0] sel;} mcuic_row_t;
  logic clk, rst, hsel, hwrite, bk, dq, ack, reti, req, hrdy, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, lvl, mlvl;
  logic [2:0] hsize;
  logic [15:0] src, vec, mvec;
  logic [7:0] did;
  logic [4:0] sel, msel;
  logic [3:0] dly, svc;
  int takes, n, error_cnt, n_compared;
  // Ordinary cases: enables, levels, control, sources, winner
  mcuic_row_t rows [10] = '{
    '{8'h82, 8'h00, 8'h00, 16'h0000, 16'h0002, 5'h01},
    '{8'hff, 8'h00, 8'h00, 16'h0000, 16'h0006, 5'h01},
    '{8'hff, 8'h00, 8'h04, 16'h0000, 16'h0006, 5'h02},
    '{8'h80, 8'hff, 8'h00, 16'h0000, 16'h8100, 5'h08},
    '{8'h80, 8'h00, 8'h00, 16'h0000, 16'h8080, 5'h0f},
    '{8'hfd, 8'h00, 8'h00, 16'h0000, 16'h0003, 5'h00},
    '{8'hff, 8'h00, 8'h40, 16'h0007, 16'h0041, 5'h06},
    '{8'h81, 8'h00, 8'h00, 16'h0001, 16'h0001, 5'h00},
    '{8'h80, 8'h80, 8'h00, 16'h0003, 16'h4000, 5'h0e},
    '{8'h80, 8'h40, 8'h00, 16'h0005, 16'h2000, 5'h0d}};
  mcuic_top dut (.i_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_src_irq(src), .i_bkpt_match(bk), .i_dbg_req(dq), .i_dbg_req_id(did),
    .i_irq_ack(ack), .i_reti(reti), .o_irq_req(req), .o_irq_vector(vec),
    .o_irq_source(sel), .o_irq_level(lvl));
  mcuic_cpu_model cpu (.i_clk(clk), .i_reset(rst), .i_irq_req(req), .i_irq_vector(vec),
    .i_irq_source(sel), .i_irq_level(lvl), .o_irq_ack(ack), .o_reti(reti),
    .i_delay(dly), .i_svc(svc), .o_takes(takes), .o_vec(mvec), .o_src(msel), .o_lvl(mlvl));
  // Clock at 125 MHz
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task restart;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  // One AHB-Lite single word transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask
  task pulse(input logic [15:0] s, input logic b, input logic d, input logic [7:0] id);
    @(posedge clk);
    src <= s;
    bk <= b;
    dq <= d;
    did <= id;
    @(posedge clk);
    src <= 16'h0000;
    bk <= 1'b0;
    dq <= 1'b0;
  endtask
  // Wait for the model to take a vector, bounded
  task take(input logic [4:0] s, input logic [15:0] v, input logic [1:0] l);
    int k;
    k = 0;
    while (takes == n && k < 80)
    begin
      @(posedge clk);
      k++;
    end
    chk(takes, n + 1);
    n = takes;
    chk({27'h0, msel}, {27'h0, s});
    chk({16'h0, mvec}, {16'h0, v});
    chk({30'h0, mlvl}, {30'h0, l});
  endtask
  task idle_chk;
    repeat (12) @(posedge clk);
    chk(takes, n);
  endtask
  function automatic logic [15:0] vexp(input logic [4:0] s, input logic [15:0] c);
    logic [11:0] b;
    b = (s == 5'h10) ? 12'h080 : (s == 5'h11) ? 12'h0c0 : 12'h003 + {4'h0, s, 3'h0};
    return {c[0] ? {c[2:1], 2'h3} : 4'h0, b};
  endfunction
  function automatic logic [1:0] lexp(input logic [4:0] s, input logic [7:0] p);
    if (s > 5'h0f)
      return 2'h3;
    if (s < 5'h07 && p[s[2:0]])
      return 2'h2;
    return 2'h1;
  endfunction
  // Watchdog
  initial
  begin
    #200000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run;
  end
  // Main sequence
  initial
  begin
    {rst, hsel, hwrite, bk, dq, htrans, haddr, hwdata, src, did} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    dly = 4'h0;
    svc = 4'h0;
    foreach (rows[i])
    begin
      restart;
      n = 0;
      wr(mcuic_pkg::ADDR_CTRL, {16'h0, rows[i].ctrl});
      wr(mcuic_pkg::ADDR_IE, {24'h0, rows[i].ie});
      wr(mcuic_pkg::ADDR_EXT_SOURCE_ENABLE, {24'h0, rows[i].ext_source_enable});
      wr(mcuic_pkg::ADDR_IP, {24'h0, rows[i].ip});
      pulse(rows[i].src, 1'b0, 1'b0, 8'h00);
      take(rows[i].sel, vexp(rows[i].sel, rows[i].ctrl), lexp(rows[i].sel, rows[i].ip));
    end
    $display("test table done");
    restart;
    chk({31'h0, req}, 32'h0);
    rdc(mcuic_pkg::ADDR_IE, 32'h0);
    rdc(mcuic_pkg::ADDR_EXT_SOURCE_ENABLE, 32'h0);
    wr(mcuic_pkg::ADDR_IP, 32'hff);
    rdc(mcuic_pkg::ADDR_IP, 32'h7f);
    wr(8'h40, 32'hff);
    rdc(8'h40, 32'h0);
    $display("test registers done");
    restart;
    n = 0;
    pulse(16'h0083, 1'b0, 1'b0, 8'h00);
    idle_chk;
    rdc(mcuic_pkg::ADDR_FLAGS, 32'h83);
    wr(mcuic_pkg::ADDR_FLAGS, 32'hffffffff);
    rdc(mcuic_pkg::ADDR_FLAGS, 32'h2);
    wr(mcuic_pkg::ADDR_IE, 32'h82);
    take(5'h01, 16'h000b, 2'h1);
    rdc(mcuic_pkg::ADDR_FLAGS, 32'h0);
    $display("test flags done");
    restart;
    n = 0;
    pulse(16'h0000, 1'b0, 1'b1, 8'h00);
    idle_chk;
    wr(mcuic_pkg::ADDR_CTRL, 32'h5a08);
    pulse(16'h0000, 1'b0, 1'b1, 8'h5b);
    idle_chk;
    pulse(16'h0000, 1'b1, 1'b1, 8'h5a);
    take(5'h11, 16'h00c0, 2'h3);
    idle_chk;
    wr(mcuic_pkg::ADDR_FLAGS, 32'h0002_0000);
    svc <= 4'h3;
    take(5'h10, 16'h0080, 2'h3);
    svc <= 4'h0;
    $display("test debug done");
    restart;
    n = 0;
    dly <= 4'h3;
    wr(mcuic_pkg::ADDR_IE, 32'hff);
    wr(mcuic_pkg::ADDR_IP, 32'h02);
    pulse(16'h0001, 1'b0, 1'b0, 8'h00);
    take(5'h00, 16'h0003, 2'h1);
    pulse(16'h0004, 1'b0, 1'b0, 8'h00);
    idle_chk;
    pulse(16'h0002, 1'b0, 1'b0, 8'h00);
    take(5'h01, 16'h000b, 2'h2);
    rdc(mcuic_pkg::ADDR_STATUS, 32'h0000_000e);
    wr(mcuic_pkg::ADDR_FLAGS, 32'h0000_0001);
    svc <= 4'h3;
    take(5'h02, 16'h0013, 2'h1);
    $display("test preemption done");
    complete_run;
  end
endmodule
